// file: design/rsi_pkg.sv
// package: register offsets, field positions and reset values of the reset state initializer
package rsi_pkg;
    // apb register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_PWR = 8'h08;
    localparam logic [7:0] OFS_PC = 8'h0C;
    localparam logic [7:0] OFS_INTCTL = 8'h10;
    localparam logic [7:0] OFS_PIRF = 8'h14;
    localparam logic [7:0] OFS_WORK = 8'h18;
    localparam logic [7:0] OFS_PTR = 8'h1C;
    localparam logic [7:0] OFS_TMR = 8'h20;
    localparam logic [7:0] OFS_PORTB = 8'h24;
    localparam logic [7:0] OFS_CONV = 8'h28;
    localparam logic [7:0] OFS_EVENT = 8'h2C;
    // status field positions
    localparam int ST_TIMEOUT = 4;
    localparam int ST_POWERDOWN = 3;
    // power status field positions
    localparam int PW_BROWNOUT = 0;
    localparam int PW_POR = 1;
    localparam int PW_PARITY = 2;
    // global irq enable position in irq control
    localparam int IC_IRQ_ENABLE = 7;
    // program counter values, power-on reset values and register masks
    localparam logic [10:0] PC_RESET = 11'h000;
    localparam logic [10:0] PC_VECTOR = 11'h004;
    localparam logic [7:0] STATUS_POR = 8'h18;
    localparam logic [7:0] POR_PWR = 8'h04;
    localparam logic [2:0] PWR_MASK_FULL = 3'h7;
    localparam logic [2:0] PWR_MASK_BOR = 3'h3;
    localparam logic [2:0] PWR_MASK_NOPER = 3'h3;
    localparam logic [7:0] PIRF_MASK = 8'h01;
    // event codes written to the event register
    localparam logic [3:0] EV_EXT_RUN = 4'h1;
    localparam logic [3:0] EV_EXT_HALT = 4'h2;
    localparam logic [3:0] EV_WD_RST = 4'h3;
    localparam logic [3:0] EV_WD_WAKE = 4'h4;
    localparam logic [3:0] EV_BROWNOUT = 4'h5;
    localparam logic [3:0] EV_PARITY = 4'h6;
    localparam logic [3:0] EV_IRQ_WAKE = 4'h7;

    typedef struct packed {
        logic [10:0] pc;
        logic [7:0] status;
        logic [2:0] pwr;
        logic [7:0] intctl;
        logic [7:0] pirf;
        logic [7:0] work;
        logic [7:0] ptr;
        logic [7:0] tmr;
        logic [7:0] portb;
        logic [7:0] conv;
        logic [3:0] last_ev;
        logic [31:0] rdata;
        logic ready;
    } rsi_state_t;
endpackage

// file: design/rsi_top.sv
// module: reset cause recording and register initialisation with apb access
// Summary of operation
// - irq wake with enable set jumps to vector
// - run pin reset: pc zero, top three cleared
// - halt pin reset: pc zero, timeout set, powerdown clear
// - irq wake: next address, timeout set, powerdown clear
// - wake sources keep their irq flags set
// - unimplemented bits always read zero
// - data registers keep contents across events
// - no power status register in variant
// - no brownout cause in variant
// - power-on flag cleared only by power-on
// - brownout flag cleared by brownout reset
// - parity flag: parity clears, power-on sets
// - every reset clears global irq enable
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
module rsi_top #(
    parameter bit HAS_PWR = 1'b1,
    parameter bit HAS_BOR = 1'b1,
    parameter bit HAS_PER = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_reset_pin_n,
    input wire logic watchdog_timer_expire,
    input wire logic brownout_det,
    input wire logic parity_error_det,
    input wire logic irq_wake,
    input wire logic [7:0] irq_wake_flags,
    input wire logic [7:0] periph_wake_flags,
    input wire logic halted,
    output logic [10:0] pc_target,
    output logic pc_load
);
    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers; source pulses are edge detected after two flops
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    logic [4:0] sync3_reg;
    logic [4:0] raw;
    logic [4:0] rise;
    assign raw = {irq_wake, parity_error_det, brownout_det, watchdog_timer_expire,
                  ~ext_reset_pin_n};
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_reg <= 5'h00;
            sync2_reg <= 5'h00;
            sync3_reg <= 5'h00;
        end
        else
        begin
            sync1_reg <= raw;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end
    // reset low matches the idle pin level, so no false edge follows reset
    assign rise = sync2_reg & ~sync3_reg;

    ////////////////////////////////////////////////////////////////////////////
    // state
    rsi_pkg::rsi_state_t st_reg;
    rsi_pkg::rsi_state_t st_next;
    logic load_next;
    logic load_reg;
    logic wr;
    logic rd;
    logic brownout_ev;
    logic per_ev;
    assign wr = psel & penable & pwrite;
    assign rd = psel & ~penable & ~pwrite;
    // parameter-only mask, so the reset branch still loads a constant
    localparam logic [2:0] pwr_mask = HAS_PWR ?
        (rsi_pkg::PWR_MASK_FULL & {HAS_PER, 1'b1, HAS_BOR}) : 3'h0;
    assign brownout_ev = rise[2] & HAS_BOR;
    assign per_ev = rise[3] & HAS_PER;

    always_comb
    begin
        st_next = st_reg;
        load_next = 1'b0;
        st_next.ready = psel & ~penable;
        // software access; event logic below has priority over writes
        if (wr)
        begin
            case (paddr)
                rsi_pkg::OFS_STATUS: st_next.status = pwdata[7:0];
                rsi_pkg::OFS_PWR: st_next.pwr = pwdata[2:0] & pwr_mask;
                rsi_pkg::OFS_INTCTL: st_next.intctl = pwdata[7:0];
                rsi_pkg::OFS_PIRF: st_next.pirf = pwdata[7:0] & rsi_pkg::PIRF_MASK;
                rsi_pkg::OFS_WORK: st_next.work = pwdata[7:0];
                rsi_pkg::OFS_PTR: st_next.ptr = pwdata[7:0];
                rsi_pkg::OFS_TMR: st_next.tmr = pwdata[7:0];
                rsi_pkg::OFS_PORTB: st_next.portb = pwdata[7:0];
                rsi_pkg::OFS_CONV: st_next.conv = pwdata[7:0];
                rsi_pkg::OFS_PC: st_next.pc = pwdata[10:0];
                default: st_next.status = st_reg.status;
            endcase
        end
        // data registers are never touched by events below
        if (rise[0] && !halted)
        begin
            st_next.pc = rsi_pkg::PC_RESET;
            st_next.status[7:5] = 3'h0;
            st_next.intctl[rsi_pkg::IC_IRQ_ENABLE] = 1'b0;
            st_next.last_ev = rsi_pkg::EV_EXT_RUN;
            load_next = 1'b1;
        end
        else if (rise[0])
        begin
            st_next.pc = rsi_pkg::PC_RESET;
            st_next.status[7:5] = 3'h0;
            st_next.status[rsi_pkg::ST_TIMEOUT] = 1'b1;
            st_next.status[rsi_pkg::ST_POWERDOWN] = 1'b0;
            st_next.intctl[rsi_pkg::IC_IRQ_ENABLE] = 1'b0;
            st_next.last_ev = rsi_pkg::EV_EXT_HALT;
            load_next = 1'b1;
        end
        else if (brownout_ev)
        begin
            st_next.pc = rsi_pkg::PC_RESET;
            st_next.status[7:5] = 3'h0;
            st_next.status[rsi_pkg::ST_TIMEOUT] = 1'b1;
            st_next.status[rsi_pkg::ST_POWERDOWN] = 1'b1;
            st_next.pwr[rsi_pkg::PW_BROWNOUT] = 1'b0;
            st_next.intctl[rsi_pkg::IC_IRQ_ENABLE] = 1'b0;
            st_next.last_ev = rsi_pkg::EV_BROWNOUT;
            load_next = 1'b1;
        end
        else if (per_ev)
        begin
            st_next.pc = rsi_pkg::PC_RESET;
            st_next.status[rsi_pkg::ST_TIMEOUT] = 1'b1;
            st_next.status[rsi_pkg::ST_POWERDOWN] = 1'b1;
            st_next.pwr[rsi_pkg::PW_PARITY] = 1'b0;
            st_next.intctl[rsi_pkg::IC_IRQ_ENABLE] = 1'b0;
            st_next.last_ev = rsi_pkg::EV_PARITY;
            load_next = 1'b1;
        end
        else if (rise[1] && !halted)
        begin
            st_next.pc = rsi_pkg::PC_RESET;
            st_next.status[7:5] = 3'h0;
            st_next.status[rsi_pkg::ST_TIMEOUT] = 1'b0;
            st_next.status[rsi_pkg::ST_POWERDOWN] = 1'b1;
            st_next.intctl[rsi_pkg::IC_IRQ_ENABLE] = 1'b0;
            st_next.last_ev = rsi_pkg::EV_WD_RST;
            load_next = 1'b1;
        end
        else if (rise[1])
        begin
            st_next.pc = st_reg.pc + 11'h001;
            st_next.status[rsi_pkg::ST_TIMEOUT] = 1'b0;
            st_next.status[rsi_pkg::ST_POWERDOWN] = 1'b0;
            st_next.last_ev = rsi_pkg::EV_WD_WAKE;
            load_next = 1'b1;
        end
        else if (rise[4] && halted)
        begin
            st_next.pc = st_reg.intctl[rsi_pkg::IC_IRQ_ENABLE] ? rsi_pkg::PC_VECTOR
                                                               : st_reg.pc + 11'h001;
            st_next.status[rsi_pkg::ST_TIMEOUT] = 1'b1;
            st_next.status[rsi_pkg::ST_POWERDOWN] = 1'b0;
            st_next.intctl = st_next.intctl | irq_wake_flags;
            st_next.pirf = st_next.pirf | (periph_wake_flags & rsi_pkg::PIRF_MASK);
            st_next.last_ev = rsi_pkg::EV_IRQ_WAKE;
            load_next = 1'b1;
        end
        // read mux, unimplemented bits zero
        st_next.rdata = 32'h0000_0000;
        if (rd)
        begin
            case (paddr)
                rsi_pkg::OFS_STATUS: st_next.rdata = {24'h0, st_reg.status};
                rsi_pkg::OFS_PWR: st_next.rdata = {29'h0, st_reg.pwr & pwr_mask};
                rsi_pkg::OFS_PC: st_next.rdata = {21'h0, st_reg.pc};
                rsi_pkg::OFS_INTCTL: st_next.rdata = {24'h0, st_reg.intctl};
                rsi_pkg::OFS_PIRF: st_next.rdata = {24'h0, st_reg.pirf};
                rsi_pkg::OFS_WORK: st_next.rdata = {24'h0, st_reg.work};
                rsi_pkg::OFS_PTR: st_next.rdata = {24'h0, st_reg.ptr};
                rsi_pkg::OFS_TMR: st_next.rdata = {24'h0, st_reg.tmr};
                rsi_pkg::OFS_PORTB: st_next.rdata = {24'h0, st_reg.portb};
                rsi_pkg::OFS_CONV: st_next.rdata = {24'h0, st_reg.conv};
                rsi_pkg::OFS_EVENT: st_next.rdata = {28'h0, st_reg.last_ev};
                default: st_next.rdata = 32'h0000_0000;
            endcase
        end
        else if (psel && penable)
        begin
            st_next.rdata = st_reg.rdata;
        end
    end

    // presetn is the power-on reset; undefined data registers start at zero here
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_reg <= '0;
            st_reg.status <= rsi_pkg::STATUS_POR;
            st_reg.pwr <= rsi_pkg::POR_PWR[2:0] & pwr_mask;
            load_reg <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
            st_reg.pwr <= st_next.pwr & pwr_mask;
            load_reg <= load_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs; no wait state on any access
    assign pready = st_reg.ready;
    assign pslverr = 1'b0;
    assign prdata = st_reg.rdata;
    assign pc_target = st_reg.pc;
    assign pc_load = load_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // each event check excludes the higher priority sources of the same edge
    chk_irq_vector: assert property (rise[4] && halted && !rise[0] && !brownout_ev
        && !per_ev && !rise[1] && st_reg.intctl[rsi_pkg::IC_IRQ_ENABLE]
        |=> pc_target == rsi_pkg::PC_VECTOR) else $error("vector not loaded");
    chk_run_reset: assert property (rise[0] && !halted |=> pc_target == 11'h000
        && st_reg.status[7:5] == 3'h0 && $stable(st_reg.status[4:0]))
        else $error("run pin reset wrong");
    chk_halt_reset: assert property (rise[0] && halted |=> st_reg.status[7:3] == 5'h02)
        else $error("halt pin reset wrong");
    chk_halt_pc: assert property (rise[0] && halted |=> pc_target == rsi_pkg::PC_RESET)
        else $error("halt pin pc wrong");
    chk_irq_wake: assert property (rise[4] && halted && rise[3:0] == 4'h0
        |=> st_reg.status[rsi_pkg::ST_TIMEOUT] && !st_reg.status[rsi_pkg::ST_POWERDOWN])
        else $error("irq wake status wrong");
    chk_irq_resume: assert property (rise[4] && halted && rise[3:0] == 4'h0
        && !st_reg.intctl[rsi_pkg::IC_IRQ_ENABLE] |=> pc_target == $past(pc_target) + 11'h001)
        else $error("irq wake address wrong");
    chk_wake_flags: assert property (rise[4] && halted && rise[3:0] == 4'h0
        |=> (st_reg.intctl & $past(irq_wake_flags)) == $past(irq_wake_flags))
        else $error("wake flags lost");
    chk_wake_pirf: assert property (rise[4] && halted && rise[3:0] == 4'h0
        |=> st_reg.pirf[0] || !$past(periph_wake_flags[0]))
        else $error("peripheral wake flag lost");
    chk_unimpl_zero: assert property (st_reg.pwr == (st_reg.pwr & pwr_mask))
        else $error("unimplemented bit set");
    chk_rdata_high: assert property (prdata[31:11] == 21'h0)
        else $error("unimplemented read bit set");
    chk_data_keep: assert property (!wr && load_next |=> $stable(st_reg.work)
        && $stable(st_reg.conv))
        else $error("data register changed");
    chk_pwr_absent: assert property (!HAS_PWR |-> st_reg.pwr == 3'h0)
        else $error("power status present");
    chk_no_brownout: assert property (!HAS_BOR
        |-> st_reg.last_ev != rsi_pkg::EV_BROWNOUT)
        else $error("brownout cause in variant");
    chk_por_flag: assert property (!wr |=> $stable(st_reg.pwr[rsi_pkg::PW_POR]))
        else $error("power-on flag changed");
    chk_bor_flag: assert property (brownout_ev && !rise[0]
        |=> !st_reg.pwr[rsi_pkg::PW_BROWNOUT]) else $error("brownout flag not cleared");
    chk_per_flag: assert property (per_ev && !rise[0] && !brownout_ev
        |=> !st_reg.pwr[rsi_pkg::PW_PARITY])
        else $error("parity flag not cleared");
    chk_gie_clear: assert property (rise[0] |=> !st_reg.intctl[rsi_pkg::IC_IRQ_ENABLE])
        else $error("irq enable not cleared");
    chk_gie_resets: assert property (rise[0] || brownout_ev || per_ev
        || (rise[1] && !halted) |=> !st_reg.intctl[rsi_pkg::IC_IRQ_ENABLE])
        else $error("reset left irq enable set");
    chk_wd_reset: assert property (rise[1] && !halted && rise[0] == 1'b0 && !brownout_ev
        && !per_ev |=> st_reg.status[4:3] == 2'b01 && pc_target == 11'h000)
        else $error("watchdog reset wrong");
    chk_wd_wake: assert property (rise[1] && halted && !rise[0] && !brownout_ev && !per_ev
        |=> st_reg.status[4:3] == 2'b00 && pc_target == $past(pc_target) + 11'h001)
        else $error("watchdog wake wrong");
    chk_bor_status: assert property (brownout_ev && !rise[0]
        |=> st_reg.status[7:3] == 5'h03) else $error("brownout status wrong");
    chk_event_load: assert property (rise[0] || rise[1] || brownout_ev || per_ev |=> pc_load)
        else $error("event without load pulse");
    chk_pready_wait: assert property (psel && !penable |=> pready)
        else $error("apb answer late");

    // covers show that the run reset, irq wake, watchdog wake, parity and brownout paths are reached
    cov_run_reset: cover property (rise[0] && !halted);
    cov_irq_wake: cover property (rise[4] && halted);
    cov_wd_wake: cover property (rise[1] && halted);
    cov_parity: cover property (per_ev);
    cov_brownout: cover property (brownout_ev);
endmodule // rsi_top

// file: verif/rsi_top_bench.sv
// bench: self-checking test of the reset state initializer against a behavioural model
`timescale 1ns/1ps
module rsi_top_bench;
////////////////////////////////////////////////////////////////////////////////
logic pclk = 1'b0;
logic presetn = 1'b0;
logic psel, penable, pwrite, pready, pslverr, pc_load;
logic ext_n, wd, bo, pe, iw, halted;
logic [7:0] paddr, wflags, pflags;
logic [31:0] pwdata, prdata, prdata_v, rd, rv;
logic [10:0] pc_target;
int mismatches = 0;
int check_count = 0;
int st, pw, pc, ic, pf, vcode, x;
int dat [5];
int seq [8] = '{7, 1, 2, 3, 4, 5, 6, 7};

always #12.5 pclk = ~pclk;

rsi_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_reset_pin_n(ext_n), .watchdog_timer_expire(wd), .brownout_det(bo),
    .parity_error_det(pe), .irq_wake(iw), .irq_wake_flags(wflags),
    .periph_wake_flags(pflags), .halted(halted), .pc_target(pc_target), .pc_load(pc_load));
// variant without power status and without brownout shares every input
rsi_top #(.HAS_PWR(1'b0), .HAS_BOR(1'b0)) dut_var (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata_v), .pready(), .pslverr(), .ext_reset_pin_n(ext_n),
    .watchdog_timer_expire(wd), .brownout_det(bo), .parity_error_det(pe), .irq_wake(iw),
    .irq_wake_flags(wflags), .periph_wake_flags(pflags), .halted(halted), .pc_target(),
    .pc_load());
////////////////////////////////////////////////////////////////////////////////
task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
        $display("== PASSED ==");
    else
        $display("== FAILED ==");
    $finish;
endtask

task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
        mismatches++;
        $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
endtask

// entered just after a rising edge, leaves just after one; one idle cycle per transfer
task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
        @(posedge pclk);
        if (pready === 1'b1)
            break;
    end
    chk("pready", {31'h0, pready}, 32'h1);
    chk("pslverr", {31'h0, pslverr}, 32'h0);
    rd = prdata;
    rv = prdata_v;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
endtask

task ev(input int k, input logic [7:0] f1, input logic [7:0] f2);
    int n;
    halted <= (k == 2 || k == 4 || k == 7);
    wflags <= f1;
    pflags <= f2;
    @(posedge pclk);
    case (k)
        1, 2: ext_n <= 1'b0;
        3, 4: wd <= 1'b1;
        5: bo <= 1'b1;
        6: pe <= 1'b1;
        default: iw <= 1'b1;
    endcase
    case (k)
        1: st = st & 8'h1F;
        2: st = (st & 8'h07) | 8'h10;
        3: st = (st & 8'h07) | 8'h08;
        4: st = st & 8'hE7;
        5:
        begin
            st = (st & 8'h07) | 8'h18;
            pw = pw & 6;
        end
        6:
        begin
            st = st | 8'h18;
            pw = pw & 3;
        end
        default:
        begin
            st = (st | 8'h10) & 8'hF7;
            ic = ic | f1;
            pf = pf | (f2 & 1);
        end
    endcase
    pc = (k == 4 || k == 7) ? ((k == 7 && ic[7]) ? 4 : (pc + 1) & 11'h7FF) : 0;
    if (k != 4 && k != 7)
        ic = ic & 8'h7F;
    vcode = (k == 5) ? vcode : k;
    for (n = 0; n < 20; n++)
    begin
        @(posedge pclk);
        if (pc_load === 1'b1)
            break;
    end
    chk("pc_load", {31'h0, pc_load}, 32'h1);
    chk("pc_target", {21'h0, pc_target}, pc);
    ext_n <= 1'b1;
    wd <= 1'b0;
    bo <= 1'b0;
    pe <= 1'b0;
    iw <= 1'b0;
    repeat (6) @(posedge pclk);
endtask

task check_all(input int k);
    int i;
    apb(1'b0, 8'h04, 32'h0);
    chk("status", rd, st);
    apb(1'b0, 8'h08, 32'h0);
    chk("power status", rd, pw);
    chk("variant power status", rv, 32'h0);
    apb(1'b0, 8'h0C, 32'h0);
    chk("pc", rd, pc);
    apb(1'b0, 8'h10, 32'h0);
    chk("irq control", rd, ic);
    apb(1'b0, 8'h14, 32'h0);
    chk("periph flags", rd, pf);
    apb(1'b0, 8'h2C, 32'h0);
    chk("event code", rd, k);
    chk("variant event code", rv, vcode);
    for (i = 0; i < 5; i++)
    begin
        apb(1'b0, 8'h18 + 8'(4 * i), 32'h0);
        chk("data register", rd, dat[i]);
    end
endtask
////////////////////////////////////////////////////////////////////////////////
initial
begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    report_and_stop();
end

initial
begin
    {psel, penable, pwrite, wd, bo, pe, iw, halted} = 8'h00;
    ext_n = 1'b1;
    {paddr, wflags, pflags, pwdata} = 56'h0;
    void'($urandom(32'h8F46D2F1));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int r = 0; r < 2; r++)
    begin
        st = 8'h18;
        pw = 4;
        {pc, ic, pf, vcode} = 128'h0;
        dat = '{0, 0, 0, 0, 0};
        check_all(0);
        $display("test power-on %0d done", r);
        if (r == 1)
            break;
        for (int i = 0; i < 5; i++)
        begin
            x = $urandom;
            dat[i] = x & 8'hFF; // upper bits are unimplemented
            apb(1'b1, 8'h18 + 8'(4 * i), x);
        end
        apb(1'b1, 8'h14, 32'hFFFFFFFF);
        pf = 1;
        apb(1'b1, 8'h2C, 32'h5);
        apb(1'b1, 8'h40, $urandom);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped", rd, 32'h0);
        foreach (seq[t])
        begin
            apb(1'b1, 8'h08, 32'h7);
            pw = 7;
            ic = (t == 7) ? (ic & 8'h7F) : (ic | 8'h80);
            apb(1'b1, 8'h10, ic);
            ev(seq[t], 8'($urandom) & 8'h7F, 8'($urandom));
            check_all(seq[t]);
            $display("test event %0d done", seq[t]);
        end
        // second power-on in mid-run
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    end
    report_and_stop();
end
endmodule // rsi_top_bench
